// *** pkg/bmf_pkg.sv ***
// bmf_pkg: register map, field positions, timing counts and encodings
// for the block-move / flag / opcode-class unit.
// assumes a single 10 MHz clock; one cpu state equals one clock cycle.
package bmf_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_COUNT = 8'h04;
    localparam logic [7:0] REG_SRC = 8'h08;
    localparam logic [7:0] REG_DST = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_CCR = 8'h14;
    localparam logic [7:0] REG_OPA = 8'h18;
    localparam logic [7:0] REG_OPB = 8'h1C;
    localparam logic [7:0] REG_FOP = 8'h20;
    localparam logic [7:0] REG_OPCODE = 8'h24;
    localparam logic [7:0] REG_DECODE = 8'h28;

    localparam int unsigned CTRL_GO_BYTE = 0;
    localparam int unsigned CTRL_GO_WORD = 1;
    localparam int unsigned FOP_LONG_BIT = 4;

    localparam int unsigned CCR_H = 5;
    localparam int unsigned CCR_N = 3;
    localparam int unsigned CCR_Z = 2;
    localparam int unsigned CCR_V = 1;
    localparam int unsigned CCR_C = 0;
    localparam logic [7:0] CCR_RESET = 8'h80;

    localparam logic [4:0] HC_WORD_BIT = 5'd11;
    localparam logic [4:0] HC_LONG_BIT = 5'd27;
    localparam logic [7:0] DAA_LIMIT = 8'h99;

    localparam int unsigned SETUP_STATES = 8;
    localparam int unsigned BYTE_STATES = 4;
    localparam int unsigned ELAPSED_W = 20;

    localparam logic [3:0] NIB_BRANCH = 4'h4;
    localparam logic [3:0] NIB_BITOP = 4'h7;

    typedef enum logic [2:0] {
        FOP_ADD = 3'h0, FOP_SUB = 3'h1, FOP_ADD_WITH_CARRY = 3'h2, FOP_SUBTRACT_WITH_BORROW = 3'h3,
        FOP_DAA = 3'h4, FOP_DIVU = 3'h5, FOP_DIVS = 3'h6, FOP_NONE = 3'h7
    } bmf_fop_e;

    typedef enum logic [2:0] {
        CLS_OTHER = 3'h0, CLS_BRANCH = 3'h1, CLS_BITOP = 3'h2, CLS_BLKMOVE = 3'h3,
        CLS_SECONDARY = 3'h4, CLS_ADD_WITH_CARRY = 3'h5, CLS_SUBTRACT_WITH_BORROW = 3'h6
    } bmf_cls_e;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01, ST_SETUP = 6'h02, ST_RD = 6'h04,
        ST_RDH = 6'h08, ST_WR = 6'h10, ST_UPD = 6'h20
    } bmf_state_e;
endpackage : bmf_pkg

// *** testbench/bmf_mem_model.sv ***
// bmf_mem_model: byte-wide on-chip memory on the far side of the move port.
// assumes requests are levels held until mem_ready; slow mode holds each access one cycle.
`timescale 1ns/1ps
module bmf_mem_model (
    input wire logic sys_clk,
    input wire logic slow,
    input wire logic [31:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic mem_ready
);
    logic [7:0] mem [0:1023];
    logic [7:0] last_q = 8'h00;
    logic hold_q = 1'b0;
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = i[7:0] ^ 8'hA5;
        end
    end
    // slow mode stalls every access once, whatever its phase, so the move length grows
    assign mem_ready = !slow || hold_q;
    // idle bus shows the inverted last byte, never a stale copy
    assign mem_rdata = mem_rd ? mem[mem_addr[9:0]] : ~last_q;
    always @(posedge sys_clk) begin
        hold_q <= (mem_rd || mem_wr) && !mem_ready;
        if (mem_rd && mem_ready) begin
            last_q <= mem[mem_addr[9:0]];
        end
        if (mem_wr && mem_ready) begin
            mem[mem_addr[9:0]] <= mem_wdata;
        end
    end
endmodule : bmf_mem_model

// *** testbench/tb.sv ***
// tb: apb-driven tests of block moves, flag rules and opcode classing.
// assumes zero-wait apb slave and the memory model above on the move port.
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic mem_ready;
    logic [7:0] ccr;
    logic busy;
    logic slow = 1'b0;
    logic [31:0] rd_v;
    logic err_v;
    int miscompares = 0;
    int n_checks = 0;

    always #50 sys_clk = ~sys_clk;

    bmf_core i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ready(mem_ready), .ccr(ccr), .busy(busy));
    bmf_mem_model i_mem (.sys_clk(sys_clk), .slow(slow), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ready(mem_ready));

    task test_done;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        cmp(rd_v & mask, exp);
    endtask : chk

    // one flag bit after an operation, from a known starting ccr
    task flag(input logic [7:0] c, input logic [31:0] a, input logic [31:0] b,
              input logic [7:0] op, input int unsigned bitn, input logic exp);
        apb(bmf_pkg::REG_CCR, 1'b1, {24'h0, c});
        apb(bmf_pkg::REG_OPA, 1'b1, a);
        apb(bmf_pkg::REG_OPB, 1'b1, b);
        apb(bmf_pkg::REG_FOP, 1'b1, {24'h0, op});
        chk(bmf_pkg::REG_CCR, 32'h1 << bitn, {31'h0, exp} << bitn);
    endtask : flag

    task dec(input logic [15:0] code, input logic [31:0] mask, input logic [31:0] exp);
        apb(bmf_pkg::REG_OPCODE, 1'b1, {16'h0, code});
        chk(bmf_pkg::REG_DECODE, mask, exp);
    endtask : dec

    // start a move and wait for busy to drop; the watchdog bounds the wait
    task move(input logic [15:0] n, input logic [31:0] s, input logic [31:0] d,
              input logic [31:0] go);
        apb(bmf_pkg::REG_COUNT, 1'b1, {16'h0, n});
        apb(bmf_pkg::REG_SRC, 1'b1, s);
        apb(bmf_pkg::REG_DST, 1'b1, d);
        apb(bmf_pkg::REG_CTRL, 1'b1, go);
        @(posedge sys_clk);
        while (busy !== 1'b0) @(posedge sys_clk);
    endtask : move

    function automatic logic [31:0] pat(input int i);
        return {24'h0, i[7:0] ^ 8'hA5};
    endfunction : pat

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        chk(bmf_pkg::REG_CCR, 32'hFF, {24'h0, bmf_pkg::CCR_RESET});
        chk(bmf_pkg::REG_STATUS, 32'hFFFF_FFFF, 32'h0);
        apb(8'h2C, 1'b0, 32'h0);
        cmp({31'h0, err_v}, 32'h1);
        cmp(rd_v, 32'h0);
        apb(bmf_pkg::REG_CCR, 1'b1, 32'hAF);
        move(16'h0103, 32'h40, 32'h100, 32'h1);
        chk(bmf_pkg::REG_STATUS, 32'hFFFF_F003, (32'd20 << 12) | 32'h2);
        chk(bmf_pkg::REG_COUNT, 32'hFFFF, 32'h0100);
        chk(bmf_pkg::REG_SRC, 32'hFFFF_FFFF, 32'h43);
        chk(bmf_pkg::REG_DST, 32'hFFFF_FFFF, 32'h103);
        for (int k = 0; k < 4; k++) cmp({24'h0, i_mem.mem[256 + k]}, pat(k < 3 ? 64 + k : 259));
        chk(bmf_pkg::REG_CCR, 32'hFF, 32'hAF);
        cmp({24'h0, ccr}, 32'hAF);
        move(16'h0102, 32'h0, 32'h200, 32'h2);
        chk(bmf_pkg::REG_STATUS, 32'hFFFF_F003, (32'd1040 << 12) | 32'h2);
        chk(bmf_pkg::REG_COUNT, 32'hFFFF, 32'h0);
        cmp({24'h0, i_mem.mem[513]}, pat(1));
        cmp({24'h0, i_mem.mem[769]}, pat(65));
        cmp({24'h0, i_mem.mem[770]}, pat(770));
        chk(bmf_pkg::REG_CCR, 32'hFF, 32'hAF);
        move(16'h0000, 32'h10, 32'h180, 32'h1);
        chk(bmf_pkg::REG_STATUS, 32'hFFFF_F003, (32'd8 << 12) | 32'h2);
        move(16'h0000, 32'h10, 32'h180, 32'h2);
        chk(bmf_pkg::REG_STATUS, 32'hFFFF_F003, (32'd8 << 12) | 32'h2);
        cmp({24'h0, i_mem.mem[384]}, pat(384));
        slow <= 1'b1;
        move(16'h0002, 32'h60, 32'h140, 32'h1);
        apb(bmf_pkg::REG_STATUS, 1'b0, 32'h0);
        cmp({31'h0, rd_v[31:12] > 20'd16}, 32'h1);
        cmp({24'h0, i_mem.mem[321]}, pat(97));
        slow <= 1'b0;
        flag(8'h80, 32'h0800, 32'h0800, 8'h00, bmf_pkg::CCR_H, 1'b1);
        flag(8'h80, 32'h0001, 32'h0001, 8'h00, bmf_pkg::CCR_H, 1'b0);
        flag(8'h80, 32'h1000, 32'h0001, 8'h01, bmf_pkg::CCR_H, 1'b1);
        flag(8'h80, 32'h0800_0000, 32'h0800_0000, 8'h10, bmf_pkg::CCR_H, 1'b1);
        flag(8'h80, 32'h0000_0800, 32'h0000_0800, 8'h10, bmf_pkg::CCR_H, 1'b0);
        flag(8'h84, 32'h0, 32'h0, 8'h02, bmf_pkg::CCR_Z, 1'b1);
        flag(8'h84, 32'h1, 32'h0, 8'h02, bmf_pkg::CCR_Z, 1'b0);
        flag(8'h84, 32'h5, 32'h5, 8'h03, bmf_pkg::CCR_Z, 1'b1);
        flag(8'h80, 32'h0, 32'h0, 8'h03, bmf_pkg::CCR_Z, 1'b0);
        flag(8'h80, 32'h9A, 32'h0, 8'h04, bmf_pkg::CCR_C, 1'b1);
        flag(8'h81, 32'h12, 32'h0, 8'h04, bmf_pkg::CCR_C, 1'b1);
        flag(8'h80, 32'h12, 32'h0, 8'h04, bmf_pkg::CCR_C, 1'b0);
        flag(8'h80, 32'h0100, 32'h80, 8'h05, bmf_pkg::CCR_N, 1'b1);
        flag(8'h88, 32'h0100, 32'h01, 8'h05, bmf_pkg::CCR_N, 1'b0);
        flag(8'h80, 32'h0100, 32'h00, 8'h05, bmf_pkg::CCR_Z, 1'b1);
        flag(8'h84, 32'h0100, 32'h02, 8'h06, bmf_pkg::CCR_Z, 1'b0);
        flag(8'h80, 32'hFFF6, 32'h02, 8'h06, bmf_pkg::CCR_N, 1'b1);
        flag(8'h88, 32'h000A, 32'h02, 8'h06, bmf_pkg::CCR_N, 1'b0);
        dec(16'h4000, 32'h0F7, 32'h001);
        dec(16'h4F00, 32'h0F7, 32'h0F1);
        dec(16'h7400, 32'h107, 32'h002);
        dec(16'h7780, 32'h107, 32'h102);
        dec(16'h0100, 32'h007, 32'h004);
        dec(16'h7B00, 32'h007, 32'h003);
        dec(16'h0E00, 32'h007, 32'h005);
        dec(16'h1E00, 32'h007, 32'h006);
        dec(16'h0000, 32'h007, 32'h000);
        test_done();
    end

    // whole run is under two thousand cycles; this margin only catches a hang
    initial begin
        #(20000 * 100);
        miscompares++;
        test_done();
    end
endmodule : tb

// *** verilog/bmf_core.sv ***
// bmf_core: memory-to-memory block move engine, condition-flag evaluator
// and first-byte opcode classifier, all behind an apb slave.
// assumes on-chip memory answers with mem_ready in the same cycle;
// a slower target simply holds mem_ready low.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module bmf_core (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ready,
    output logic [7:0] ccr,
    output logic busy
);
    function automatic logic half_carry(input logic [31:0] a, input logic [31:0] b,
                                        input logic cin, input logic sub,
                                        input logic [4:0] top);
        logic [32:0] m;
        logic [32:0] t;
        m = (33'h1 << (top + 5'd1)) - 33'h1;
        t = sub ? (({1'b0, a} & m) - ({1'b0, b} & m) - {32'h0, cin})
                : (({1'b0, a} & m) + ({1'b0, b} & m) + {32'h0, cin});
        half_carry = t[top + 5'd1];
    endfunction : half_carry

    function automatic logic [31:0] absv(input logic [31:0] x);
        absv = x[31] ? (32'h0 - x) : x;
    endfunction : absv

    bmf_pkg::bmf_state_e state_q, state_d;
    logic word_form_q;
    logic [15:0] count_q;
    logic [15:0] n0_q;
    logic [31:0] src_q, dst_q, opa_q, opb_q;
    logic [7:0] byte_q, ccr_q;
    logic [2:0] setup_cnt_q;
    localparam int unsigned ELAPSED_W_L = bmf_pkg::ELAPSED_W;
    logic [ELAPSED_W_L-1:0] elapsed_q;
    logic done_q, stalled_q;
    logic [15:0] opcode_q;
    logic [31:0] prdata_q;

    // apb decode; zero wait states
    wire wr_en = psel & penable & pwrite;
    wire hit = (paddr <= bmf_pkg::REG_DECODE) && (paddr[1:0] == 2'b00);
    wire idle = (state_q == bmf_pkg::ST_IDLE);
    wire wr_ctrl = wr_en & (paddr == bmf_pkg::REG_CTRL) & idle;
    wire start = wr_ctrl & (pwdata[bmf_pkg::CTRL_GO_BYTE] | pwdata[bmf_pkg::CTRL_GO_WORD]);
    wire start_word = pwdata[bmf_pkg::CTRL_GO_WORD];
    // flag evaluation refused during a move so flags stay put
    wire wr_fop = wr_en & (paddr == bmf_pkg::REG_FOP) & idle;
    wire wr_ccr = wr_en & (paddr == bmf_pkg::REG_CCR) & idle;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // block move sequencing
    wire [15:0] cur_count = word_form_q ? count_q : {8'h00, count_q[7:0]};
    wire count_zero = (cur_count == 16'h0000);
    wire last_byte = (cur_count == 16'h0001);
    wire setup_end = (setup_cnt_q == 3'(bmf_pkg::SETUP_STATES - 1));
    wire [15:0] count_dec = word_form_q ? (count_q - 16'h0001)
                                        : {count_q[15:8], count_q[7:0] - 8'h01};
    wire finish = ((state_q == bmf_pkg::ST_SETUP) & setup_end & count_zero)
                | ((state_q == bmf_pkg::ST_UPD) & last_byte);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            bmf_pkg::ST_IDLE: if (start) state_d = bmf_pkg::ST_SETUP;
            bmf_pkg::ST_SETUP: begin
                if (setup_end) state_d = count_zero ? bmf_pkg::ST_IDLE : bmf_pkg::ST_RD;
            end
            // a slow target stretches the move; mem_ready low holds the state
            bmf_pkg::ST_RD: if (mem_ready) state_d = bmf_pkg::ST_RDH;
            bmf_pkg::ST_RDH: state_d = bmf_pkg::ST_WR;
            bmf_pkg::ST_WR: if (mem_ready) state_d = bmf_pkg::ST_UPD;
            bmf_pkg::ST_UPD: state_d = last_byte ? bmf_pkg::ST_IDLE : bmf_pkg::ST_RD;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= bmf_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            setup_cnt_q <= 3'h0;
        end else if (state_q == bmf_pkg::ST_SETUP) begin
            setup_cnt_q <= setup_cnt_q + 3'h1;
        end else begin
            setup_cnt_q <= 3'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_q <= 16'h0000;
            src_q <= 32'h0;
            dst_q <= 32'h0;
            word_form_q <= 1'b0;
        end else if (state_q == bmf_pkg::ST_UPD) begin
            count_q <= count_dec;
            src_q <= src_q + 32'h1;
            dst_q <= dst_q + 32'h1;
        end else if (idle && wr_en) begin
            if (paddr == bmf_pkg::REG_COUNT) count_q <= pwdata[15:0];
            if (paddr == bmf_pkg::REG_SRC) src_q <= pwdata;
            if (paddr == bmf_pkg::REG_DST) dst_q <= pwdata;
            if (start) word_form_q <= start_word;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            byte_q <= 8'h00;
        end else if ((state_q == bmf_pkg::ST_RD) && mem_ready) begin
            byte_q <= mem_rdata;
        end
    end

    // elapsed states of the last move, for software profiling
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            elapsed_q <= '0;
            n0_q <= 16'h0000;
            done_q <= 1'b0;
            stalled_q <= 1'b0;
        end else if (start) begin
            elapsed_q <= '0;
            n0_q <= start_word ? count_q : {8'h00, count_q[7:0]};
            done_q <= 1'b0;
            stalled_q <= 1'b0;
        end else if (!idle) begin
            elapsed_q <= elapsed_q + 1'b1;
            done_q <= finish;
            stalled_q <= stalled_q | (((state_q == bmf_pkg::ST_RD)
                         | (state_q == bmf_pkg::ST_WR)) & ~mem_ready);
        end
    end

    assign mem_rd = (state_q == bmf_pkg::ST_RD);
    assign mem_wr = (state_q == bmf_pkg::ST_WR);
    assign mem_addr = mem_wr ? dst_q : src_q;
    assign mem_wdata = byte_q;
    assign busy = ~idle;

    // condition flag evaluation
    wire is_long = pwdata[bmf_pkg::FOP_LONG_BIT];
    wire [2:0] fop = pwdata[2:0];
    wire is_sub = (fop == bmf_pkg::FOP_SUB) | (fop == bmf_pkg::FOP_SUBTRACT_WITH_BORROW);
    wire is_x = (fop == bmf_pkg::FOP_ADD_WITH_CARRY) | (fop == bmf_pkg::FOP_SUBTRACT_WITH_BORROW);
    wire cin = is_x & ccr_q[bmf_pkg::CCR_C];
    wire [32:0] sum = is_sub ? ({1'b0, opa_q} - {1'b0, opb_q} - {32'h0, cin})
                             : ({1'b0, opa_q} + {1'b0, opb_q} + {32'h0, cin});
    wire [16:0] sum_w = is_sub ? ({1'b0, opa_q[15:0]} - {1'b0, opb_q[15:0]} - {16'h0, cin})
                               : ({1'b0, opa_q[15:0]} + {1'b0, opb_q[15:0]} + {16'h0, cin});
    wire res_zero = is_long ? (sum[31:0] == 32'h0) : (sum_w[15:0] == 16'h0);
    wire res_neg = is_long ? sum[31] : sum_w[15];
    wire res_carry = is_long ? sum[32] : sum_w[16];
    wire sa = is_long ? opa_q[31] : opa_q[15];
    wire sb = is_long ? opb_q[31] : opb_q[15];
    wire res_ovf = is_sub ? ((sa ^ sb) & (sa ^ res_neg)) : (~(sa ^ sb) & (sa ^ res_neg));
    wire hc = half_carry(opa_q, opb_q, cin, is_sub,
                         is_long ? bmf_pkg::HC_LONG_BIT : bmf_pkg::HC_WORD_BIT);
    // divide: word form divides by a byte, long form by a word
    wire div_neg = is_long ? opb_q[15] : opb_q[7];
    wire div_zero = is_long ? (opb_q[15:0] == 16'h0) : (opb_q[7:0] == 8'h00);
    wire [31:0] dvd = is_long ? opa_q : {{16{opa_q[15]}}, opa_q[15:0]};
    wire [31:0] dvs = is_long ? {{16{opb_q[15]}}, opb_q[15:0]} : {{24{opb_q[7]}}, opb_q[7:0]};
    // quotient is nonzero only when |dividend| reaches |divisor|
    wire quo_neg = (dvd[31] ^ dvs[31]) & ~div_zero & (absv(dvd) >= absv(dvs));
    wire daa_carry = ccr_q[bmf_pkg::CCR_C] | (opa_q[7:0] > bmf_pkg::DAA_LIMIT);

    logic [7:0] ccr_d;
    always_comb begin
        ccr_d = ccr_q;
        unique case (bmf_pkg::bmf_fop_e'(fop))
            bmf_pkg::FOP_ADD, bmf_pkg::FOP_SUB, bmf_pkg::FOP_ADD_WITH_CARRY, bmf_pkg::FOP_SUBTRACT_WITH_BORROW: begin
                ccr_d[bmf_pkg::CCR_H] = hc;
                ccr_d[bmf_pkg::CCR_N] = res_neg;
                ccr_d[bmf_pkg::CCR_V] = res_ovf;
                ccr_d[bmf_pkg::CCR_C] = res_carry;
                ccr_d[bmf_pkg::CCR_Z] = is_x ? (ccr_q[bmf_pkg::CCR_Z] & res_zero) : res_zero;
            end
            bmf_pkg::FOP_DAA: ccr_d[bmf_pkg::CCR_C] = daa_carry;
            bmf_pkg::FOP_DIVU: begin
                ccr_d[bmf_pkg::CCR_N] = div_neg;
                ccr_d[bmf_pkg::CCR_Z] = div_zero;
            end
            bmf_pkg::FOP_DIVS: begin
                ccr_d[bmf_pkg::CCR_N] = quo_neg;
                ccr_d[bmf_pkg::CCR_Z] = div_zero;
            end
            bmf_pkg::FOP_NONE: ccr_d = ccr_q;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ccr_q <= bmf_pkg::CCR_RESET;
            opa_q <= 32'h0;
            opb_q <= 32'h0;
            opcode_q <= 16'h0000;
        end else begin
            if (wr_ccr) ccr_q <= pwdata[7:0];
            else if (wr_fop) ccr_q <= ccr_d;
            if (wr_en && paddr == bmf_pkg::REG_OPA) opa_q <= pwdata;
            if (wr_en && paddr == bmf_pkg::REG_OPB) opb_q <= pwdata;
            if (wr_en && paddr == bmf_pkg::REG_OPCODE) opcode_q <= pwdata[15:0];
        end
    end
    assign ccr = ccr_q;

    // first-byte classification
    wire [3:0] first_byte_upper_nibble = opcode_q[15:12];
    wire [3:0] first_byte_lower_nibble = opcode_q[11:8];
    wire [3:0] second_byte_upper_nibble = opcode_q[7:4];
    wire [15:0] al_bit = 16'h1 << first_byte_lower_nibble;
    localparam logic [3:0] NIB_BITOP_L = bmf_pkg::NIB_BITOP;
    wire secondary = ((first_byte_upper_nibble == 4'h0) & |(al_bit & 16'h8C02))
                   | ((first_byte_upper_nibble == 4'h1) & |(al_bit & 16'h8C8F))
                   | ((first_byte_upper_nibble == 4'h5) & al_bit[8])
                   | ((first_byte_upper_nibble == NIB_BITOP_L) & |(al_bit & 16'hF600));
    wire shared_cell = (first_byte_upper_nibble == bmf_pkg::NIB_BITOP)
                     & (first_byte_lower_nibble[3:2] == 2'b01);
    wire variant = shared_cell & second_byte_upper_nibble[3];
    logic [2:0] cls;
    always_comb begin
        cls = bmf_pkg::CLS_OTHER;
        if (first_byte_upper_nibble == bmf_pkg::NIB_BRANCH) cls = bmf_pkg::CLS_BRANCH;
        else if (secondary) cls = bmf_pkg::CLS_SECONDARY;
        else if (shared_cell) cls = bmf_pkg::CLS_BITOP;
        else if (opcode_q[15:8] == 8'h7B) cls = bmf_pkg::CLS_BLKMOVE;
        else if (opcode_q[15:8] == 8'h0E || first_byte_upper_nibble == 4'h9) cls = bmf_pkg::CLS_ADD_WITH_CARRY;
        else if (opcode_q[15:8] == 8'h1E || first_byte_upper_nibble == 4'hB) cls = bmf_pkg::CLS_SUBTRACT_WITH_BORROW;
    end
    // branch condition index is the lower nibble in table order
    wire [3:0] cond = (cls == bmf_pkg::CLS_BRANCH) ? first_byte_lower_nibble : 4'h0;

    // register read mux, captured in the setup phase
    logic [31:0] rd_mux;
    always_comb begin
        unique case (paddr)
            bmf_pkg::REG_COUNT: rd_mux = {16'h0, count_q};
            bmf_pkg::REG_SRC: rd_mux = src_q;
            bmf_pkg::REG_DST: rd_mux = dst_q;
            bmf_pkg::REG_STATUS: rd_mux = {elapsed_q, 10'h0, done_q, busy};
            bmf_pkg::REG_CCR: rd_mux = {24'h0, ccr_q};
            bmf_pkg::REG_OPA: rd_mux = opa_q;
            bmf_pkg::REG_OPB: rd_mux = opb_q;
            bmf_pkg::REG_OPCODE: rd_mux = {16'h0, opcode_q};
            bmf_pkg::REG_DECODE: rd_mux = {23'h0, variant, cond, 1'b0, cls};
            default: rd_mux = 32'h0;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (rst) prdata_q <= 32'h0;
        else if (psel && !penable) prdata_q <= rd_mux;
    end
    assign prdata = prdata_q;

    int unsigned n_bytes;
    assign n_bytes = 32'(n0_q);

    AST_BYTE_DEC: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == bmf_pkg::ST_UPD && !word_form_q |=>
        count_q[7:0] == $past(count_q[7:0]) - 8'h01 && count_q[15:8] == $past(count_q[15:8]))
        else $error("byte count not decremented");
    AST_WORD_DEC: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == bmf_pkg::ST_UPD && word_form_q |=> count_q == $past(count_q) - 16'h0001)
        else $error("word count not decremented");
    AST_ZERO_SKIP: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == bmf_pkg::ST_SETUP && setup_end && count_zero |=> idle && !mem_wr)
        else $error("zero count move touched memory");
    AST_FLAGS_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        busy |=> $stable(ccr_q))
        else $error("flags changed during move");
    AST_TIMING: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(busy) && !stalled_q |->
        32'(elapsed_q) == bmf_pkg::SETUP_STATES + bmf_pkg::BYTE_STATES * n_bytes)
        else $error("move length wrong");
    AST_HALF_CARRY: assert property (@(posedge sys_clk) disable iff (rst)
        wr_fop && fop == bmf_pkg::FOP_ADD && !is_long |=> ccr_q[bmf_pkg::CCR_H]
        == $past(({1'b0, opa_q[11:0]} + {1'b0, opb_q[11:0]}) > 13'h0FFF))
        else $error("half carry at bit 11 wrong");
    AST_ADD_WITH_CARRY_Z: assert property (@(posedge sys_clk) disable iff (rst)
        wr_fop && is_x && !ccr_q[bmf_pkg::CCR_Z] |=> !ccr_q[bmf_pkg::CCR_Z])
        else $error("extended op set zero flag");
    AST_DAA_C: assert property (@(posedge sys_clk) disable iff (rst)
        wr_fop && fop == bmf_pkg::FOP_DAA && ccr_q[bmf_pkg::CCR_C] |=> ccr_q[bmf_pkg::CCR_C])
        else $error("decimal adjust lost carry");
    AST_DIV_Z: assert property (@(posedge sys_clk) disable iff (rst)
        wr_fop && (fop == bmf_pkg::FOP_DIVU || fop == bmf_pkg::FOP_DIVS)
        |=> ccr_q[bmf_pkg::CCR_Z] == $past(div_zero))
        else $error("divide zero flag wrong");
    AST_VARIANT: assert property (@(posedge sys_clk) disable iff (rst)
        cls == bmf_pkg::CLS_BITOP |-> opcode_q[15:10] == 6'h1D && variant == opcode_q[7])
        else $error("inverted variant misselected");
    AST_BRANCH: assert property (@(posedge sys_clk) disable iff (rst)
        first_byte_upper_nibble == bmf_pkg::NIB_BRANCH |-> cls == bmf_pkg::CLS_BRANCH
        && cond == first_byte_lower_nibble)
        else $error("branch decode wrong");
    CV_BYTE_MOVE: cover property (@(posedge sys_clk) $fell(busy) && !word_form_q && n0_q != 16'h0000);
    CV_WORD_MOVE: cover property (@(posedge sys_clk) $fell(busy) && word_form_q && n0_q > 16'h0001);
    CV_STALL: cover property (@(posedge sys_clk) mem_rd && !mem_ready);
endmodule : bmf_core
